// *** design/ccts_top.sv ***
// Purpose: time-base select register for capture channels nine and ten
// Assumes: register strobes and mode inputs are on clk_sys_in
// Notes: vector bit 0 is channel nine, bit 1 is channel ten
`timescale 1ns/1ps
`default_nettype none
module ccts_top (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [ccts_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ccts_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ccts_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [ccts_pkg::NUM_CHAN-1:0] pwm_mode_in,
  output logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr1_sel_out,
  output logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr5_sel_out,
  output logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr2_sel_out,
  output logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr8_sel_out,
  output logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr10_sel_out,
  output logic [ccts_pkg::NUM_CHAN-1:0] pwm_resv_out
);

  // carrier to the register store
  ccts_reg_if reg_bus ();

  // decoder results before the output flops
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr1_dec;
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr5_dec;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr2_dec;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr8_dec;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr10_dec;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_resv_dec;

  // per-channel field, indexed like the outputs
  logic [ccts_pkg::FIELD_W-1:0] chan_field [ccts_pkg::NUM_CHAN];

  // output registers and their next values
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr1_r;
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr5_r;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr2_r;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr8_r;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr10_r;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_resv_r;
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr1_nxt;
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr5_nxt;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr2_nxt;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr8_nxt;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr10_nxt;
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_resv_nxt;

  // drive the carrier from the plain port
  assign reg_bus.addr = reg_addr_in;
  assign reg_bus.wdata = reg_wdata_in;
  assign reg_bus.wr = reg_wr_in;
  assign reg_bus.rd = reg_rd_in;
  assign reg_rdata_out = reg_bus.rdata;

  // fields in channel order
  assign chan_field[0] = reg_bus.chan_nine_timer_sel;
  assign chan_field[1] = reg_bus.chan_ten_timer_sel;

  // register store
  ccts_regfile u_regs (
    .clk_sys_in (clk_sys_in),
    .resetn_in (resetn_in),
    .bus (reg_bus.regs)
  );

  // one decoder per channel
  for (genvar ch = 0; ch < ccts_pkg::NUM_CHAN; ch++) begin : g_chan
    ccts_chan_decode u_dec (
      .field_in (chan_field[ch]),
      .pwm_mode_in (pwm_mode_in[ch]),
      .cc_tmr1_out (cc_tmr1_dec[ch]),
      .cc_tmr5_out (cc_tmr5_dec[ch]),
      .pwm_tmr2_out (pwm_tmr2_dec[ch]),
      .pwm_tmr8_out (pwm_tmr8_dec[ch]),
      .pwm_tmr10_out (pwm_tmr10_dec[ch]),
      .pwm_resv_out (pwm_resv_dec[ch])
    );
  end

  // next values: selects follow the decoders every cycle
  always_comb begin
    cc_tmr1_nxt = cc_tmr1_dec;
    cc_tmr5_nxt = cc_tmr5_dec;
    pwm_tmr2_nxt = pwm_tmr2_dec;
    pwm_tmr8_nxt = pwm_tmr8_dec;
    pwm_tmr10_nxt = pwm_tmr10_dec;
    pwm_resv_nxt = pwm_resv_dec;
  end

  // output flops; a flop here keeps timer muxes glitch-free at a cost of one cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cc_tmr1_r <= '0;
      cc_tmr5_r <= '0;
      pwm_tmr2_r <= '0;
      pwm_tmr8_r <= '0;
      pwm_tmr10_r <= '0;
      pwm_resv_r <= '0;
    end else begin
      cc_tmr1_r <= cc_tmr1_nxt;
      cc_tmr5_r <= cc_tmr5_nxt;
      pwm_tmr2_r <= pwm_tmr2_nxt;
      pwm_tmr8_r <= pwm_tmr8_nxt;
      pwm_tmr10_r <= pwm_tmr10_nxt;
      pwm_resv_r <= pwm_resv_nxt;
    end
  end

  // outputs straight from flops
  assign cc_tmr1_sel_out = cc_tmr1_r;
  assign cc_tmr5_sel_out = cc_tmr5_r;
  assign pwm_tmr2_sel_out = pwm_tmr2_r;
  assign pwm_tmr8_sel_out = pwm_tmr8_r;
  assign pwm_tmr10_sel_out = pwm_tmr10_r;
  assign pwm_resv_out = pwm_resv_r;

  // channel ten capture/compare follows field bit 2, whatever bit 3 holds
  a_ten_cc_base: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !pwm_mode_in[1] |=> cc_tmr5_sel_out[1] == $past(reg_bus.chan_ten_timer_sel[0])
      && cc_tmr1_sel_out[1] == !$past(reg_bus.chan_ten_timer_sel[0])
      && pwm_tmr2_sel_out[1] == 1'b0 && pwm_resv_out[1] == 1'b0)
    else $error("channel ten capture time base wrong");

  // channel ten pwm table
  a_ten_pwm_map: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    pwm_mode_in[1] |=>
      pwm_tmr2_sel_out[1] == ($past(reg_bus.chan_ten_timer_sel) == 2'h0)
      && pwm_tmr8_sel_out[1] == ($past(reg_bus.chan_ten_timer_sel) == 2'h1)
      && pwm_tmr10_sel_out[1] == ($past(reg_bus.chan_ten_timer_sel) == 2'h2)
      && cc_tmr1_sel_out[1] == 1'b0 && cc_tmr5_sel_out[1] == 1'b0)
    else $error("channel ten pwm timer wrong");

  // reserved code selects no timer
  a_ten_pwm_resv: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (pwm_mode_in[1] && reg_bus.chan_ten_timer_sel == 2'h3) |=>
      pwm_resv_out[1] && !(pwm_tmr2_sel_out[1] || pwm_tmr8_sel_out[1] || pwm_tmr10_sel_out[1]))
    else $error("channel ten reserved code not flagged");

  // channel nine capture/compare follows field bit 0
  a_nine_cc_base: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !pwm_mode_in[0] |=> cc_tmr5_sel_out[0] == $past(reg_bus.chan_nine_timer_sel[0])
      && cc_tmr1_sel_out[0] == !$past(reg_bus.chan_nine_timer_sel[0]))
    else $error("channel nine capture time base wrong");

  // channel nine pwm table, reserved included
  a_nine_pwm_map: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    pwm_mode_in[0] |=>
      pwm_tmr2_sel_out[0] == ($past(reg_bus.chan_nine_timer_sel) == 2'h0)
      && pwm_tmr8_sel_out[0] == ($past(reg_bus.chan_nine_timer_sel) == 2'h1)
      && pwm_tmr10_sel_out[0] == ($past(reg_bus.chan_nine_timer_sel) == 2'h2)
      && pwm_resv_out[0] == ($past(reg_bus.chan_nine_timer_sel) == 2'h3))
    else $error("channel nine pwm timer wrong");

  // write stores the low nibble only, and a read in the next cycle shows it
  a_write_then_read: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (reg_wr_in && reg_addr_in == 8'h00) ##1 (reg_rd_in && reg_addr_in == 8'h00) |=>
      reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 2)})
    else $error("written value not read back with upper bits zero");

  // upper nibble never reads nonzero
  a_resv_read_zero: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    reg_rd_in |=> reg_rdata_out[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");

  // read data stand one cycle only
  a_rdata_one_cycle: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");

endmodule : ccts_top
`default_nettype wire

// *** design/ccts_pkg.sv ***
// Purpose: constants and types for the high-channel timer select block
// Assumes: one 8-bit register on a plain strobe port, 250 MHz system clock
// Notes: channel index 0 is channel nine, index 1 is channel ten
//
// Summary of operation
// - channel ten capture/compare: field bit 2 picks timer5/timer1
// - channel ten pwm: 00 t2, 01 t8, 10 t10, 11 reserved
// - channel nine capture/compare: field bit 0 picks timer5/timer1
// - bits 7-4 read zero, writes ignored
package ccts_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FIELD_W = 2;
  localparam int NUM_CHAN = 2;

  // register offset on the port
  localparam logic [ADDR_W-1:0] SEL_REG_OFF = 8'h00;

  // reset value and implemented bits
  localparam logic [DATA_W-1:0] SEL_REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SEL_REG_IMPL_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // field positions (low bit of each field)
  localparam int CHAN_NINE_LSB = 0;
  localparam int CHAN_TEN_LSB = 2;

  // field bit that steers the capture/compare time base
  localparam int CC_SEL_BIT = 0;

  // pwm period timer codes
  localparam logic [FIELD_W-1:0] PWM_CODE_TMR2 = 2'h0;
  localparam logic [FIELD_W-1:0] PWM_CODE_TMR8 = 2'h1;
  localparam logic [FIELD_W-1:0] PWM_CODE_TMR10 = 2'h2;
  localparam logic [FIELD_W-1:0] PWM_CODE_RESV = 2'h3;

  // decoded pwm period timer
  typedef enum logic [1:0] {
    CCTS_PWM_TMR2,
    CCTS_PWM_TMR8,
    CCTS_PWM_TMR10,
    CCTS_PWM_RESV
  } ccts_pwm_tmr_t;

endpackage : ccts_pkg

// *** design/ccts_reg_if.sv ***
// Purpose: carrier between the top and the register store
// Assumes: all signals on clk_sys_in
// Notes: field outputs are the stored register bits
`timescale 1ns/1ps
`default_nettype none
interface ccts_reg_if;
  logic [ccts_pkg::ADDR_W-1:0] addr; // register address
  logic [ccts_pkg::DATA_W-1:0] wdata; // write data
  logic wr; // write strobe
  logic rd; // read strobe
  logic [ccts_pkg::DATA_W-1:0] rdata; // read data, one cycle after rd
  logic [ccts_pkg::FIELD_W-1:0] chan_ten_timer_sel; // stored field, bits 3-2
  logic [ccts_pkg::FIELD_W-1:0] chan_nine_timer_sel; // stored field, bits 1-0

  // top side drives the access
  modport host (
    output addr, wdata, wr, rd,
    input rdata, chan_ten_timer_sel, chan_nine_timer_sel
  );

  // register store side
  modport regs (
    input addr, wdata, wr, rd,
    output rdata, chan_ten_timer_sel, chan_nine_timer_sel
  );
endinterface : ccts_reg_if
`default_nettype wire

// *** design/ccts_regfile.sv ***
// Purpose: storage and read-back of the timer select register
// Assumes: strobes never both high; one-cycle strobes
// Notes: unmapped reads return zero, unmapped writes do nothing
`timescale 1ns/1ps
`default_nettype none
module ccts_regfile (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  ccts_reg_if.regs bus
);

  logic [ccts_pkg::DATA_W-1:0] sel_r; // only low nibble is ever nonzero
  logic [ccts_pkg::DATA_W-1:0] sel_nxt;
  logic [ccts_pkg::DATA_W-1:0] rdata_r; // read answer register
  logic [ccts_pkg::DATA_W-1:0] rdata_nxt;

  // next values for store and read answer
  always_comb begin
    sel_nxt = sel_r;
    rdata_nxt = ccts_pkg::RDATA_IDLE;
    if (bus.wr && bus.addr == ccts_pkg::SEL_REG_OFF) begin
      // upper bits are masked off so they never store
      sel_nxt = bus.wdata & ccts_pkg::SEL_REG_IMPL_MASK;
    end
    if (bus.rd && bus.addr == ccts_pkg::SEL_REG_OFF) begin
      // mask again so reserved bits read zero by construction
      rdata_nxt = sel_r & ccts_pkg::SEL_REG_IMPL_MASK;
    end
  end

  // registers only
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_r <= ccts_pkg::SEL_REG_RESET;
      rdata_r <= ccts_pkg::RDATA_IDLE;
    end else begin
      sel_r <= sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // field taps
  assign bus.rdata = rdata_r;
  assign bus.chan_ten_timer_sel = sel_r[ccts_pkg::CHAN_TEN_LSB +: ccts_pkg::FIELD_W];
  assign bus.chan_nine_timer_sel = sel_r[ccts_pkg::CHAN_NINE_LSB +: ccts_pkg::FIELD_W];

endmodule : ccts_regfile
`default_nettype wire

// *** design/ccts_chan_decode.sv ***
// Purpose: turn one channel's 2-bit select field into timer selects
// Assumes: pwm_mode_in comes from same-clock channel logic
// Notes: purely combinational; the top registers the results
`timescale 1ns/1ps
`default_nettype none
module ccts_chan_decode (
  input wire logic [ccts_pkg::FIELD_W-1:0] field_in,
  input wire logic pwm_mode_in,
  output logic cc_tmr1_out,
  output logic cc_tmr5_out,
  output logic pwm_tmr2_out,
  output logic pwm_tmr8_out,
  output logic pwm_tmr10_out,
  output logic pwm_resv_out
);

  ccts_pkg::ccts_pwm_tmr_t pwm_tmr; // decoded period timer

  // map code to period timer; same table for both channels
  always_comb begin
    case (field_in)
      ccts_pkg::PWM_CODE_TMR2: pwm_tmr = ccts_pkg::CCTS_PWM_TMR2;
      ccts_pkg::PWM_CODE_TMR8: pwm_tmr = ccts_pkg::CCTS_PWM_TMR8;
      ccts_pkg::PWM_CODE_TMR10: pwm_tmr = ccts_pkg::CCTS_PWM_TMR10;
      default: pwm_tmr = ccts_pkg::CCTS_PWM_RESV;
    endcase
  end

  // selects are gated by mode so exactly one family is live
  always_comb begin
    // only the low field bit matters here, high bit ignored
    cc_tmr5_out = !pwm_mode_in && field_in[ccts_pkg::CC_SEL_BIT];
    cc_tmr1_out = !pwm_mode_in && !field_in[ccts_pkg::CC_SEL_BIT];
    pwm_tmr2_out = pwm_mode_in && pwm_tmr == ccts_pkg::CCTS_PWM_TMR2;
    pwm_tmr8_out = pwm_mode_in && pwm_tmr == ccts_pkg::CCTS_PWM_TMR8;
    pwm_tmr10_out = pwm_mode_in && pwm_tmr == ccts_pkg::CCTS_PWM_TMR10;
    // reserved code selects no timer at all, flagged instead
    pwm_resv_out = pwm_mode_in && pwm_tmr == ccts_pkg::CCTS_PWM_RESV;
  end

endmodule : ccts_chan_decode
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the high-channel timer select block
// Assumes: strobe register port with read data one cycle after the strobe
// Notes: no partner model; the bench drives every input of the block itself
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_in; // 250 MHz system clock
  logic resetn_in; // async reset, active low
  logic [ccts_pkg::ADDR_W-1:0] reg_addr_in; // register address
  logic [ccts_pkg::DATA_W-1:0] reg_wdata_in; // write data
  logic reg_wr_in; // write strobe
  logic reg_rd_in; // read strobe
  logic [ccts_pkg::DATA_W-1:0] reg_rdata_out; // read answer
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_mode_in; // per channel mode, 1 = pwm
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr1_sel_out; // capture/compare on timer1
  logic [ccts_pkg::NUM_CHAN-1:0] cc_tmr5_sel_out; // capture/compare on timer5
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr2_sel_out; // pwm on timer2
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr8_sel_out; // pwm on timer8
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_tmr10_sel_out; // pwm on timer10
  logic [ccts_pkg::NUM_CHAN-1:0] pwm_resv_out; // pwm with reserved code
  int bad_count; // mismatches seen
  int n_checks; // comparisons made

  ccts_top i_dut (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .pwm_mode_in(pwm_mode_in),
    .cc_tmr1_sel_out(cc_tmr1_sel_out),
    .cc_tmr5_sel_out(cc_tmr5_sel_out),
    .pwm_tmr2_sel_out(pwm_tmr2_sel_out),
    .pwm_tmr8_sel_out(pwm_tmr8_sel_out),
    .pwm_tmr10_sel_out(pwm_tmr10_sel_out),
    .pwm_resv_out(pwm_resv_out)
  );

  // free-running clock, 4 ns period
  initial clk_sys_in = 1'b0;
  always #2 clk_sys_in = ~clk_sys_in;

  // one comparison, case equality so an unknown never matches
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // one-cycle write; entered and left in the time step of a rising edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  // one-cycle read; data looked at mid-cycle, the only cycle it stands
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("read data", {8'h00, exp}, {8'h00, reg_rdata_out});
    @(posedge clk_sys_in);
  endtask : reg_read

  // expected one-hot selector set {resv, t10, t8, t2, t5, t1} for one channel
  function automatic logic [5:0] exp_sel(input logic [1:0] f, input logic m);
    if (!m) begin
      exp_sel = f[0] ? 6'h02 : 6'h01; // high field bit ignored
    end else begin
      exp_sel = 6'h04 << f; // 00 t2, 01 t8, 10 t10, 11 reserved
    end
  endfunction : exp_sel

  // gathers both channels' selectors, channel ten in the upper half
  function automatic logic [15:0] got_sel();
    got_sel = {4'h0, pwm_resv_out[1], pwm_tmr10_sel_out[1], pwm_tmr8_sel_out[1],
      pwm_tmr2_sel_out[1], cc_tmr5_sel_out[1], cc_tmr1_sel_out[1],
      pwm_resv_out[0], pwm_tmr10_sel_out[0], pwm_tmr8_sel_out[0],
      pwm_tmr2_sel_out[0], cc_tmr5_sel_out[0], cc_tmr1_sel_out[0]};
  endfunction : got_sel

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    logic [7:0] v;
    bad_count = 0;
    n_checks = 0;
    resetn_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    pwm_mode_in = 2'h0;
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("reset selectors", {4'h0, exp_sel(2'h0, 1'b0), exp_sel(2'h0, 1'b0)}, got_sel());
    @(posedge clk_sys_in);
    reg_read(ccts_pkg::SEL_REG_OFF, 8'h00);
    // write straight into a read: upper nibble must not stick
    reg_write(ccts_pkg::SEL_REG_OFF, 8'hff);
    reg_read(ccts_pkg::SEL_REG_OFF, 8'h0f);
    @(negedge clk_sys_in);
    chk("idle read data", 16'h0000, {8'h00, reg_rdata_out});
    @(posedge clk_sys_in);
    // unmapped address: write ignored, read answers zero
    reg_write(8'h01, 8'h05);
    reg_read(8'h01, 8'h00);
    reg_read(ccts_pkg::SEL_REG_OFF, 8'h0f);
    // every field value under every mode pair, junk in the upper nibble
    for (int i = 0; i < 64; i++) begin
      v = 8'(i >> 2);
      pwm_mode_in <= 2'(i);
      reg_write(ccts_pkg::SEL_REG_OFF, {v[3:0], v[3:0]});
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("selectors", {4'h0, exp_sel(v[3:2], i[1]), exp_sel(v[1:0], i[0])}, got_sel());
      @(posedge clk_sys_in);
      reg_read(ccts_pkg::SEL_REG_OFF, {4'h0, v[3:0]});
    end
    // second reset in mid-run clears the register and drops every selector
    resetn_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("selectors in reset", 16'h0000, got_sel());
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    pwm_mode_in <= 2'h0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("selectors after reset", {4'h0, exp_sel(2'h0, 1'b0), exp_sel(2'h0, 1'b0)}, got_sel());
    @(posedge clk_sys_in);
    reg_read(ccts_pkg::SEL_REG_OFF, ccts_pkg::SEL_REG_RESET);
    close_out();
  end
endmodule : tb
`default_nettype wire
